// ==== rtl/ocfg_channel.sv ====
// Contract
// RULE1: two-bit field picks pll1, pll2, primary, secondary reference
// RULE2: driver type: off, ac differential, hcsl, lvcmos
// RULE3: mode one: tail current, or lvcmos positive pin
// RULE4: mode two: hcsl load, or lvcmos negative pin
// RULE5: divide ratio is field value plus one
// RULE6: divider acts only on pll sources
// RULE7: reference sources pass through undivided always
//
// Implementation choice: strobed register access.
module ocfg_channel (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // candidate clock sources, asynchronous to ref_clk
    input wire logic pll1_clk,
    input wire logic pll2_clk,
    input wire logic ref_pri_clk,
    input wire logic ref_sec_clk,
    // output driver pins
    output logic out_p,
    output logic out_p_oe,
    output logic out_n,
    output logic out_n_oe,
    // analog driver settings
    output logic [1:0] tail_current_code,
    output logic [1:0] hcsl_load_code
);
    import ocfg_pkg::*;
`include "ocfg_defs.svh"

    ocfg_state_t q;
    ocfg_state_t d;
    logic sel_lvl;
    logic clk_div;
    logic [1:0] pin_p;
    logic [1:0] pin_n;

    // {oe, level} of one lvcmos pin for a mode code
    function automatic logic [1:0] ocfg_cmos_pin(input logic [1:0] code, input logic clk);
        case (ocfg_pin_t'(code))
            OCFG_PIN_TRI: ocfg_cmos_pin = 2'h0;
            OCFG_PIN_LOW: ocfg_cmos_pin = 2'h2;
            OCFG_PIN_INV: ocfg_cmos_pin = {1'b1, ~clk};
            OCFG_PIN_TRUE: ocfg_cmos_pin = {1'b1, clk};
            default: ocfg_cmos_pin = 2'h0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // source selection and division
    // ----------------------------------------------------------------
    // sources are sampled as levels, so they must stay well below half of ref_clk
    assign sel_lvl = q.sync2[q.src]; // RULE1

    ocfg_divider u_div (
        .ref_clk(ref_clk),
        .reset(reset),
        .src_lvl(sel_lvl),
        .bypass(q.src[1]), // RULE6 RULE7
        .div_value(q.div),
        .clk_div_q(clk_div)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.sync1 = {ref_sec_clk, ref_pri_clk, pll2_clk, pll1_clk};
        d.sync2 = q.sync1;

        // register writes
        if (reg_wr && reg_addr == `OCFG_CTRL_OFFSET)
        begin
            d.src = ocfg_src_t'(reg_wdata[`OCFG_SRC_LSB +: 2]); // RULE1
            d.drv = ocfg_drv_t'(reg_wdata[`OCFG_DRV_LSB +: 2]); // RULE2
            d.mode1 = reg_wdata[`OCFG_MODE1_LSB +: 2]; // RULE3
            d.mode2 = reg_wdata[`OCFG_MODE2_LSB +: 2]; // RULE4
        end
        if (reg_wr && reg_addr == `OCFG_DIV_OFFSET)
        begin
            d.div = reg_wdata; // RULE5
        end

        // read data valid only in the cycle after the strobe
        d.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `OCFG_CTRL_OFFSET: d.rdata = {q.src, q.drv, q.mode1, q.mode2};
                `OCFG_DIV_OFFSET: d.rdata = q.div;
                default: d.rdata = 8'h00;
            endcase
        end

        // driver
        pin_p = ocfg_cmos_pin(q.mode1, clk_div);
        pin_n = ocfg_cmos_pin(q.mode2, clk_div);
        d.itail = 2'h0;
        d.rload = 2'h0;
        case (q.drv)
            OCFG_DRV_OFF:
            begin
                d.out_p = 1'b0; // RULE2
                d.oe_p = 1'b0;
                d.out_n = 1'b0;
                d.oe_n = 1'b0;
            end
            OCFG_DRV_DIFF:
            begin
                d.out_p = clk_div; // RULE2
                d.oe_p = 1'b1;
                d.out_n = ~clk_div;
                d.oe_n = 1'b1;
                d.itail = q.mode1; // RULE3
            end
            OCFG_DRV_HCSL:
            begin
                // a tristate load code floats the pair
                d.out_p = clk_div; // RULE2
                d.oe_p = (q.mode2 != 2'h0); // RULE4
                d.out_n = ~clk_div;
                d.oe_n = (q.mode2 != 2'h0); // RULE4
                d.itail = q.mode1; // RULE3
                d.rload = q.mode2; // RULE4
            end
            OCFG_DRV_CMOS:
            begin
                {d.oe_p, d.out_p} = pin_p; // RULE3
                {d.oe_n, d.out_n} = pin_n; // RULE4
            end
            default:
            begin
                d.out_p = 1'b0;
                d.oe_p = 1'b0;
                d.out_n = 1'b0;
                d.oe_n = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            q <= '0;
            q.src <= ocfg_src_t'(`OCFG_SRC_RESET);
            q.drv <= ocfg_drv_t'(`OCFG_DRV_RESET);
            q.mode1 <= `OCFG_MODE1_RESET;
            q.mode2 <= `OCFG_MODE2_RESET;
            q.div <= `OCFG_DIV_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = q.rdata;
    assign out_p = q.out_p;
    assign out_p_oe = q.oe_p;
    assign out_n = q.out_n;
    assign out_n_oe = q.oe_n;
    assign tail_current_code = q.itail;
    assign hcsl_load_code = q.rload;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking ck @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    AST_SRC_FOLLOW: assert property ( // RULE1
        (q.src[1] && q.drv == OCFG_DRV_CMOS && q.mode1 == 2'h3
        && $stable(q.src) && $stable(q.drv) && $stable(q.mode1) && $stable(q.div))
        ##1 ($stable(q.src) && $stable(q.drv) && $stable(q.mode1) && $stable(q.div))
        |=> out_p == $past(sel_lvl, 2))
        else $error("lvcmos output does not follow the selected reference");

    AST_SRC_READBACK: assert property ( // RULE1
        (reg_wr && reg_addr == `OCFG_CTRL_OFFSET) ##1 (reg_rd && reg_addr == `OCFG_CTRL_OFFSET && !reg_wr)
        |=> reg_rdata[`OCFG_SRC_LSB +: 2] == $past(reg_wdata[`OCFG_SRC_LSB +: 2], 2))
        else $error("source field did not read back as written");

    AST_DRV_OFF: assert property ( // RULE2
        q.drv == OCFG_DRV_OFF |=> !out_p_oe && !out_n_oe)
        else $error("disabled driver still drives a pin");

    // the sampled reset keeps the attempt at the releasing edge vacuous: outputs are still cleared then
    AST_DRV_DIFF: assert property ( // RULE2
        (!reset && q.drv == OCFG_DRV_DIFF) |=> out_p_oe && out_n_oe && out_n == !out_p)
        else $error("differential driver pair is not complementary");

    AST_ITAIL: assert property ( // RULE3
        (!reset && (q.drv == OCFG_DRV_DIFF || q.drv == OCFG_DRV_HCSL)) |=> tail_current_code == $past(q.mode1))
        else $error("tail current code does not follow mode one");

    AST_CMOS_P_LOW: assert property ( // RULE3
        (q.drv == OCFG_DRV_CMOS && q.mode1 == 2'h1) |=> out_p_oe && !out_p)
        else $error("positive pin not driven low for code one");

    AST_CMOS_N_TRI: assert property ( // RULE4
        (q.drv == OCFG_DRV_CMOS && q.mode2 == 2'h0) |=> !out_n_oe)
        else $error("negative pin not floated for code zero");

    AST_HCSL_LOAD: assert property ( // RULE4
        q.drv == OCFG_DRV_HCSL |=> hcsl_load_code == $past(q.mode2) && out_p_oe == ($past(q.mode2) != 2'h0))
        else $error("hcsl load code or tristate wrong");

    AST_DIV_WRITE: assert property ( // RULE5
        (reg_wr && reg_addr == `OCFG_DIV_OFFSET) ##1 (reg_rd && reg_addr == `OCFG_DIV_OFFSET && !reg_wr)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("divider value did not read back as written");

    AST_REF_NODIV: assert property ( // RULE7
        (q.src[1] && q.drv == OCFG_DRV_DIFF
        && $stable(q.src) && $stable(q.drv) && $stable(q.mode1) && $stable(q.div))
        ##1 ($stable(q.src) && $stable(q.drv) && $stable(q.mode1) && $stable(q.div))
        |=> out_p == $past(sel_lvl, 2))
        else $error("reference divided despite divider setting");
endmodule

// ==== rtl/ocfg_defs.svh ====
`ifndef OCFG_DEFS_SVH
`define OCFG_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OCFG_CTRL_OFFSET 8'h27
`define OCFG_DIV_OFFSET 8'h28

// ----------------------------------------------------------------
// control register field positions (lsb of each 2-bit field)
// ----------------------------------------------------------------
`define OCFG_SRC_LSB 6
`define OCFG_DRV_LSB 4
`define OCFG_MODE1_LSB 2
`define OCFG_MODE2_LSB 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OCFG_SRC_RESET 2'h0
`define OCFG_DRV_RESET 2'h1
`define OCFG_MODE1_RESET 2'h2
`define OCFG_MODE2_RESET 2'h0
`define OCFG_DIV_RESET 8'h02

`endif

// ==== rtl/ocfg_pkg.sv ====
package ocfg_pkg;

    // ----------------------------------------------------------------
    // field encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OCFG_SRC_PLL1 = 2'h0,
        OCFG_SRC_PLL2 = 2'h1,
        OCFG_SRC_REF_PRI = 2'h2,
        OCFG_SRC_REF_SEC = 2'h3
    } ocfg_src_t;

    typedef enum logic [1:0] {
        OCFG_DRV_OFF = 2'h0,
        OCFG_DRV_DIFF = 2'h1,
        OCFG_DRV_HCSL = 2'h2,
        OCFG_DRV_CMOS = 2'h3
    } ocfg_drv_t;

    // single-ended pin behaviour in lvcmos mode
    typedef enum logic [1:0] {
        OCFG_PIN_TRI = 2'h0,
        OCFG_PIN_LOW = 2'h1,
        OCFG_PIN_INV = 2'h2,
        OCFG_PIN_TRUE = 2'h3
    } ocfg_pin_t;

    // ----------------------------------------------------------------
    // state records
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        ocfg_src_t src;
        ocfg_drv_t drv;
        logic [1:0] mode1;
        logic [1:0] mode2;
        logic [7:0] div;
        logic [7:0] rdata;
        logic out_p;
        logic oe_p;
        logic out_n;
        logic oe_n;
        logic [1:0] itail;
        logic [1:0] rload;
    } ocfg_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic prev;
        logic clk_out;
    } ocfg_div_state_t;

endpackage

// ==== rtl/ocfg_divider.sv ====
module ocfg_divider (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // source and setting
    input wire logic src_lvl,
    input wire logic bypass,
    input wire logic [7:0] div_value,
    // divided level
    output logic clk_div_q
);
    import ocfg_pkg::*;

    ocfg_div_state_t q;
    ocfg_div_state_t d;
    logic rise;
    logic [8:0] half;

    // ----------------------------------------------------------------
    // edge counter
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.prev = src_lvl;
        rise = src_lvl & ~q.prev;
        half = ({1'b0, div_value} + 9'h001) >> 1;
        if (bypass || div_value == 8'h00)
        begin
            // references pass undivided; a zero setting is ratio one
            d.cnt = 8'h00; // RULE6 RULE7
            d.clk_out = src_lvl; // RULE6 RULE7
        end
        else
        begin
            // >= rather than == so a shrinking setting cannot strand the count
            if (rise)
            begin
                d.cnt = (q.cnt >= div_value) ? 8'h00 : q.cnt + 8'h01; // RULE5
            end
            d.clk_out = ({1'b0, d.cnt} < half); // RULE5
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign clk_div_q = q.clk_out;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_DIV_BYPASS: assert property (@(posedge ref_clk) disable iff (reset) // RULE7
        bypass |=> clk_div_q == $past(src_lvl))
        else $error("reference source was not passed through undivided");

    AST_DIV_WRAP: assert property (@(posedge ref_clk) disable iff (reset) // RULE5
        (!bypass && div_value != 8'h00 && $stable(div_value) && rise && q.cnt == div_value) |=> q.cnt == 8'h00)
        else $error("divider count did not wrap after ratio edges");

    AST_DIV_STEP: assert property (@(posedge ref_clk) disable iff (reset) // RULE6
        (!bypass && div_value != 8'h00 && rise && q.cnt < div_value) |=> q.cnt == $past(q.cnt) + 8'h01)
        else $error("divider count did not advance on a pll edge");
endmodule

// ==== tb/ocfg_rx_model.sv ====
module ocfg_rx_model (
    // clock
    input wire logic ref_clk,
    // observed pin
    input wire logic pin_p,
    input wire logic pin_p_oe,
    // measurement
    output logic [15:0] rise_cnt,
    output logic [15:0] period
);
    timeunit 1ns;
    timeprecision 1ps;

    logic lvl_q = 1'b0;
    logic [15:0] age_q = 16'h0000;
    // an undriven pin is pulled low by the receiver termination
    wire lvl = pin_p_oe & pin_p;

    initial
    begin
        rise_cnt = 16'h0000;
        period = 16'h0000;
    end

    always @(posedge ref_clk)
    begin
        lvl_q <= lvl;
        age_q <= age_q + 16'h0001;
        if (lvl && !lvl_q)
        begin
            rise_cnt <= rise_cnt + 16'h0001;
            period <= age_q + 16'h0001;
            age_q <= 16'h0000;
        end
    end
endmodule

// ==== tb/tb_ocfg_channel.sv ====
module tb_ocfg_channel;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic pll1_clk = 1'b0;
    logic pll2_clk = 1'b0;
    logic ref_pri_clk = 1'b0;
    logic ref_sec_clk = 1'b0;
    wire [7:0] reg_rdata;
    wire out_p, out_p_oe, out_n, out_n_oe;
    wire [1:0] tail_current_code, hcsl_load_code;
    wire [15:0] rise_cnt, period;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    int sc = 0;
    // source periods in ref_clk cycles, all slow enough for the synchronisers
    localparam int PER_T [4] = '{10, 14, 8, 12};
    localparam logic [1:0] SRC_T [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
    localparam logic [7:0] DIV_T [6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'hff, 8'hff};

    ocfg_channel dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll1_clk(pll1_clk), .pll2_clk(pll2_clk),
        .ref_pri_clk(ref_pri_clk), .ref_sec_clk(ref_sec_clk), .out_p(out_p), .out_p_oe(out_p_oe),
        .out_n(out_n), .out_n_oe(out_n_oe), .tail_current_code(tail_current_code),
        .hcsl_load_code(hcsl_load_code));

    ocfg_rx_model rx (.ref_clk(ref_clk), .pin_p(out_p), .pin_p_oe(out_p_oe), .rise_cnt(rise_cnt),
        .period(period));

    always #4 ref_clk = ~ref_clk;

    // sources derived from ref_clk keep measured periods exact
    always @(posedge ref_clk)
    begin
        sc <= sc + 1;
        pll1_clk <= (sc % 10) < 5;
        pll2_clk <= (sc % 14) < 7;
        ref_pri_clk <= (sc % 8) < 4;
        ref_sec_clk <= (sc % 12) < 6;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'(reg_rdata), 16'(e));
        @(posedge ref_clk);
        #1;
        chk(16'(reg_rdata), 16'h0000);
    endtask

    // write followed by a read of the same register with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'(reg_rdata), 16'(d));
        @(posedge ref_clk);
        #1;
        chk(16'(reg_rdata), 16'h0000);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(8'h27, 8'h18);
        rd(8'h28, 8'h02);
        wr(8'h28, 8'hff);
        wr(8'h29, 8'h55);
        wr(8'h27, 8'he7);
        rd(8'h28, 8'hff);
        rd(8'h29, 8'h00);
        rd(8'h27, 8'he7);
        wr_rd(8'h28, 8'h3c);
        wr_rd(8'h27, 8'h9e);
    endtask

    task automatic t_drv();
        logic [1:0] dv, m1, m2;
        logic oep, oen;
        for (int i = 0; i < 64; i++)
        begin
            {dv, m1, m2} = 6'(i);
            wr(8'h27, {2'h2, dv, m1, m2});
            repeat (3) @(posedge ref_clk);
            #1;
            oep = (dv == 2'h1) || (dv == 2'h2 && m2 != 2'h0) || (dv == 2'h3 && m1 != 2'h0);
            oen = (dv == 2'h1) || (dv != 2'h0 && dv != 2'h1 && m2 != 2'h0);
            chk(16'({out_p_oe, out_n_oe}), 16'({oep, oen}));
            chk(16'(tail_current_code), 16'((dv == 2'h1 || dv == 2'h2) ? m1 : 2'h0));
            chk(16'(hcsl_load_code), 16'((dv == 2'h2) ? m2 : 2'h0));
            if (dv == 2'h3 && m1 == 2'h1)
                chk(16'(out_p), 16'h0000);
            if (dv == 2'h3 && m2 == 2'h1)
                chk(16'(out_n), 16'h0000);
            if (dv == 2'h1 || (dv == 2'h3 && m1 == 2'h2 && m2 == 2'h3))
                chk(16'(out_p ^ out_n), 16'h0001);
        end
    endtask

    // an old-setting rise and a switch-time rise may follow a change, so the fourth rise is judged
    task automatic t_src();
        int e;
        logic [15:0] n;
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h28, DIV_T[i]);
            wr(8'h27, {SRC_T[i], 6'h18});
            e = SRC_T[i][1] ? PER_T[SRC_T[i]] : PER_T[SRC_T[i]] * (int'(DIV_T[i]) + 1);
            n = rise_cnt;
            for (int k = 0; k < 12000 && rise_cnt != n + 16'h0004; k++)
                @(posedge ref_clk);
            #1;
            chk(period, 16'(e));
        end
    endtask

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            miscompares++;
            complete_run();
        end
    end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_drv();
        t_src();
        complete_run();
    end
endmodule
